// file: rtl/cbb_bridge.sv
// CPU system bus bridge: processor requests, snoops, APB registers.
// Assumes synchronous inputs on pclk and lookup results valid while
// the cache access semaphore is high.
`default_nettype none

module cbb_bridge (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 preq_valid,
  input  wire cbb_pkg::cbb_preq_type preq,
  output logic                      preq_ready,
  output logic                      proc_done,
  output logic                      proc_fail,
  output logic      [31:0]          proc_rdata,
  input  wire logic                 bc_hit,
  input  wire logic                 bc_dirty,
  output logic                      tag_capture,
  output logic                      tag_update,
  output logic                      pmap_update,
  output logic                      bc_write,
  output logic                      bb_write,
  output logic                      bus_req,
  input  wire logic                 bus_grant,
  output logic                      bcmd_valid,
  output cbb_pkg::cbb_bcmd_type     bcmd,
  input  wire logic                 bus_done,
  input  wire logic                 bus_shared,
  input  wire logic [31:0]          bus_rdata,
  input  wire logic                 snoop_valid,
  input  wire cbb_pkg::cbb_snoop_type snoop,
  input  wire cbb_pkg::cbb_look_type look,
  output logic                      cache_access_semaphore,
  output logic                      supply_data,
  output logic                      pcache_inval,
  output logic                      bc_inval,
  output logic                      csr_ack
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cbb_pkg::cbb_state_type state_q;
  cbb_pkg::cbb_preq_type  req_q;
  cbb_pkg::cbb_bcmd_type  bcmd_q;
  cbb_pkg::cbb_snoop_type snp_q;
  logic        lock_q, mode_q, wb_pend_q, vic_pend_q, rel_q, rdy_q;
  logic        sem_q, snp_look_q;
  logic [1:0]  outst_q, outst_d;
  logic        pready_q, pslverr_q;
  logic [31:0] prdata_q, rdata_q;
  logic        done_q, fail_q, tcap_q, tupd_q, pmap_q, bcw_q, bbw_q;
  logic        breq_q, bval_q, sup_q, pinv_q, binv_q, csr_q;
  logic        issue, lock_set, lock_clr, snp_acc, snp_end;
  logic        apb_set, apb_wr, node_hit;
  logic [1:0]  n_inc, n_dec;

  assign apb_set  = psel && !penable;
  // Writes land at the access edge, when the transfer completes.
  assign apb_wr   = psel && penable && pready_q && pwrite;
  assign issue    = (state_q == cbb_pkg::ST_ARB) && bus_grant
                    && (outst_q != cbb_pkg::MAX_OUTST);
  assign snp_acc  = snoop_valid && !snp_look_q && !sem_q;
  assign snp_end  = snp_look_q;
  assign node_hit = (snp_q.addr & cbb_pkg::NODE_MASK)
                    == cbb_pkg::NODE_BASE;

  // ----------------------------------------------------------------------
  // APB slave, no wait states
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_set;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (apb_set) begin
        case (paddr)
          cbb_pkg::OFF_MODE:   prdata_q[0] <= mode_q;
          cbb_pkg::OFF_LOCK:   prdata_q[cbb_pkg::LOCK_BIT] <= lock_q;
          cbb_pkg::OFF_STATUS: prdata_q <= {21'h0, sem_q, outst_q,
                                            3'h0, state_q};
          default:             pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= cbb_pkg::MODE_RST;
    end else if (apb_wr && paddr == cbb_pkg::OFF_MODE) begin
      mode_q <= pwdata[0];
    end
  end

  // ----------------------------------------------------------------------
  // Lock flag: hardware set wins over any clear
  // ----------------------------------------------------------------------
  assign lock_set = (state_q == cbb_pkg::ST_PROBE)
                    && req_q.kind == cbb_pkg::PK_LDL;
  assign lock_clr = (state_q == cbb_pkg::ST_PROBE)
                    && req_q.kind == cbb_pkg::PK_STC
                    && lock_q && bc_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
    end else if (lock_set) begin
      lock_q <= 1'b1;
    end else if (lock_clr) begin
      lock_q <= 1'b0;
    end else if (apb_wr && paddr == cbb_pkg::OFF_LOCK) begin
      lock_q <= pwdata[cbb_pkg::LOCK_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Processor request sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= cbb_pkg::ST_IDLE;
      req_q      <= '0;
      bcmd_q     <= '0;
      wb_pend_q  <= 1'b0;
      vic_pend_q <= 1'b0;
      rel_q      <= 1'b0;
      rdy_q      <= 1'b1;
      rdata_q    <= 32'h0000_0000;
      done_q     <= 1'b0;
      fail_q     <= 1'b0;
      tcap_q     <= 1'b0;
      tupd_q     <= 1'b0;
      pmap_q     <= 1'b0;
      bcw_q      <= 1'b0;
      bbw_q      <= 1'b0;
      breq_q     <= 1'b0;
      bval_q     <= 1'b0;
    end else begin
      done_q <= 1'b0;
      tcap_q <= 1'b0;
      tupd_q <= 1'b0;
      pmap_q <= 1'b0;
      bcw_q  <= 1'b0;
      bbw_q  <= 1'b0;
      bval_q <= 1'b0;
      rdy_q  <= 1'b0;
      case (state_q)
        cbb_pkg::ST_IDLE: begin
          rdy_q <= !preq_valid;
          if (preq_valid) begin
            req_q   <= preq;
            rel_q   <= 1'b0;
            fail_q  <= 1'b0;
            if (preq.kind == cbb_pkg::PK_BB_WR) begin
              bbw_q  <= 1'b1;
              done_q <= 1'b1;
            end else begin
              state_q <= cbb_pkg::ST_SEM;
            end
          end
        end
        cbb_pkg::ST_SEM: begin
          if (!sem_q) begin
            state_q <= cbb_pkg::ST_PROBE;
          end
        end
        cbb_pkg::ST_PROBE: begin
          bcmd_q.addr <= req_q.addr;
          wb_pend_q   <= 1'b0;
          vic_pend_q  <= 1'b0;
          state_q     <= cbb_pkg::ST_ARB;
          case (req_q.kind)
            cbb_pkg::PK_DREAD: begin
              pmap_q  <= 1'b1;
              done_q  <= 1'b1;
              state_q <= cbb_pkg::ST_IDLE;
            end
            cbb_pkg::PK_READ_BLOCK_REQUEST, cbb_pkg::PK_WRITE_BLOCK_REQUEST: begin
              tcap_q     <= 1'b1;
              bcmd_q.cmd <= cbb_pkg::CMD_READ;
              wb_pend_q  <= req_q.kind == cbb_pkg::PK_WRITE_BLOCK_REQUEST;
              vic_pend_q <= bc_dirty;
            end
            cbb_pkg::PK_LDL: begin
              bcmd_q.cmd <= cbb_pkg::CMD_READ;
              if (bc_hit) begin
                done_q  <= 1'b1;
                state_q <= cbb_pkg::ST_IDLE;
              end
            end
            cbb_pkg::PK_STC: begin
              bcmd_q.cmd <= cbb_pkg::CMD_WRITE;
              if (!lock_q) begin
                fail_q  <= 1'b1;
                done_q  <= 1'b1;
                state_q <= cbb_pkg::ST_IDLE;
              end else if (bc_hit) begin
                bcw_q   <= 1'b1;
                done_q  <= 1'b1;
                state_q <= cbb_pkg::ST_IDLE;
              end
            end
            default: begin
              bcmd_q.cmd <= cbb_pkg::CMD_PRIV;
            end
          endcase
        end
        cbb_pkg::ST_ARB: begin
          breq_q <= !issue;
          if (issue) begin
            bval_q  <= 1'b1;
            state_q <= cbb_pkg::ST_WAIT;
          end
        end
        cbb_pkg::ST_WAIT: begin
          if (bus_done) begin
            rel_q <= 1'b1;
            if (!rel_q) begin
              done_q  <= 1'b1;
              rdata_q <= bus_rdata;
            end
            if (wb_pend_q && bus_shared) begin
              wb_pend_q  <= 1'b0;
              bcmd_q.cmd <= cbb_pkg::CMD_WRITE;
              breq_q     <= 1'b1;
              state_q    <= cbb_pkg::ST_ARB;
            end else if (vic_pend_q) begin
              vic_pend_q <= 1'b0;
              bcmd_q.cmd <= cbb_pkg::CMD_VICTIM;
              breq_q     <= 1'b1;
              state_q    <= cbb_pkg::ST_ARB;
            end else begin
              tupd_q  <= 1'b1;
              rdy_q   <= rel_q;
              state_q <= cbb_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          rdy_q   <= 1'b1;
          state_q <= cbb_pkg::ST_IDLE;
        end
      endcase
      if (state_q == cbb_pkg::ST_PROBE && req_q.kind != cbb_pkg::PK_DREAD
          && !(req_q.kind == cbb_pkg::PK_LDL && bc_hit)
          && !(req_q.kind == cbb_pkg::PK_STC && (!lock_q || bc_hit))) begin
        breq_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Snoop responder
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sem_q      <= 1'b0;
      snp_look_q <= 1'b0;
      snp_q      <= '0;
      sup_q      <= 1'b0;
      pinv_q     <= 1'b0;
      binv_q     <= 1'b0;
      csr_q      <= 1'b0;
    end else begin
      sup_q  <= 1'b0;
      pinv_q <= 1'b0;
      binv_q <= 1'b0;
      csr_q  <= 1'b0;
      snp_look_q <= snp_acc;
      if (snp_acc) begin
        snp_q <= snoop;
        sem_q <= snoop.cmd == cbb_pkg::CMD_READ
                 || snoop.cmd == cbb_pkg::CMD_WRITE;
      end
      if (snp_end) begin
        sem_q <= 1'b0;
        case (snp_q.cmd)
          cbb_pkg::CMD_READ: begin
            sup_q <= look.bmap_hit && look.valid
                     && look.dirty || look.victim_match;
          end
          cbb_pkg::CMD_WRITE: begin
            if (look.bmap_hit && look.valid) begin
              pinv_q <= look.pmap_hit;
              binv_q <= !look.pmap_hit || mode_q;
            end
          end
          cbb_pkg::CMD_CSR_RD, cbb_pkg::CMD_CSR_WR: begin
            csr_q <= node_hit;
          end
          default: begin
            csr_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outstanding bus transaction count
  // ----------------------------------------------------------------------
  always_comb begin
    n_inc   = {1'b0, issue} + {1'b0, snp_acc};
    n_dec   = {1'b0, bus_done && state_q == cbb_pkg::ST_WAIT}
              + {1'b0, snp_end};
    outst_d = outst_q + n_inc - n_dec;
    if (outst_d > cbb_pkg::MAX_OUTST) begin
      outst_d = cbb_pkg::MAX_OUTST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outst_q <= 2'h0;
    end else begin
      outst_q <= outst_d;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign preq_ready = rdy_q;
  assign proc_done  = done_q;
  assign proc_fail  = fail_q;
  assign proc_rdata = rdata_q;
  assign tag_capture = tcap_q;
  assign tag_update = tupd_q;
  assign pmap_update = pmap_q;
  assign bc_write   = bcw_q;
  assign bb_write   = bbw_q;
  assign bus_req    = breq_q;
  assign bcmd_valid = bval_q;
  assign bcmd       = bcmd_q;
  assign cache_access_semaphore = sem_q;
  assign supply_data = sup_q;
  assign pcache_inval = pinv_q;
  assign bc_inval   = binv_q;
  assign csr_ack    = csr_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_NO_RSVD_CMD: assert property (@(posedge pclk) disable iff (!presetn)
    bval_q |-> bcmd_q.cmd != cbb_pkg::CMD_RSVD2
            && bcmd_q.cmd != cbb_pkg::CMD_RSVD6)
    else $error("reserved command issued");
  AST_DREAD_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == cbb_pkg::ST_PROBE && req_q.kind == cbb_pkg::PK_DREAD
    |=> pmap_q && done_q && !breq_q)
    else $error("read hit not map-only");
  AST_LDL_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    lock_set |=> lock_q)
    else $error("lock not set");
  AST_STC_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == cbb_pkg::ST_PROBE && req_q.kind == cbb_pkg::PK_STC
    && !lock_q |=> fail_q && done_q && !bcw_q && !breq_q)
    else $error("failed store not reported");
  AST_BBWR_NOBUS: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == cbb_pkg::ST_IDLE && preq_valid
    && preq.kind == cbb_pkg::PK_BB_WR |=> bbw_q && !breq_q ##1 !breq_q)
    else $error("byte write used bus");
  AST_PROBE_SEM: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_q == cbb_pkg::ST_PROBE) |-> $past(!sem_q))
    else $error("probe under semaphore");
  AST_OUTST_MAX: assert property (@(posedge pclk) disable iff (!presetn)
    bval_q |-> $past(outst_q) != cbb_pkg::MAX_OUTST)
    else $error("too many outstanding");
  AST_SEM_SPAN: assert property (@(posedge pclk) disable iff (!presetn)
    snp_acc && snoop.cmd == cbb_pkg::CMD_WRITE |=> sem_q ##1 !sem_q)
    else $error("semaphore span wrong");
  AST_VIC_IGN: assert property (@(posedge pclk) disable iff (!presetn)
    snp_end && snp_q.cmd == cbb_pkg::CMD_VICTIM
    |=> !sup_q && !binv_q && !pinv_q)
    else $error("victim write answered");
  AST_WB_SHARED: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == cbb_pkg::ST_WAIT && bus_done && wb_pend_q && bus_shared
    |=> state_q == cbb_pkg::ST_ARB && bcmd_q.cmd == cbb_pkg::CMD_WRITE)
    else $error("shared write-back missing");

  COV_BLOCK: cover property (@(posedge pclk) disable iff (!presetn)
    tupd_q);
  COV_STC_OK: cover property (@(posedge pclk) disable iff (!presetn)
    bcw_q);
  COV_VICTIM: cover property (@(posedge pclk) disable iff (!presetn)
    bval_q && bcmd_q.cmd == cbb_pkg::CMD_VICTIM);
  COV_SUPPLY: cover property (@(posedge pclk) disable iff (!presetn)
    sup_q);

endmodule : cbb_bridge

`default_nettype wire

// file: rtl/cbb_pkg.sv
// Shared constants and types for the CPU system bus bridge.
// Assumes one clock domain and an APB register port.
`default_nettype none

package cbb_pkg;

  // ----------------------------------------------------------------------
  // Bus command codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] CMD_READ   = 3'h0;
  localparam logic [2:0] CMD_WRITE  = 3'h1;
  localparam logic [2:0] CMD_RSVD2  = 3'h2;
  localparam logic [2:0] CMD_VICTIM = 3'h3;
  localparam logic [2:0] CMD_CSR_RD = 3'h4;
  localparam logic [2:0] CMD_CSR_WR = 3'h5;
  localparam logic [2:0] CMD_RSVD6  = 3'h6;
  localparam logic [2:0] CMD_PRIV   = 3'h7;

  // ----------------------------------------------------------------------
  // Processor request kinds
  // ----------------------------------------------------------------------
  localparam logic [2:0] PK_DREAD  = 3'h0;
  localparam logic [2:0] PK_READ_BLOCK_REQUEST = 3'h1;
  localparam logic [2:0] PK_WRITE_BLOCK_REQUEST = 3'h2;
  localparam logic [2:0] PK_LDL    = 3'h3;
  localparam logic [2:0] PK_STC    = 3'h4;
  localparam logic [2:0] PK_BB_RD  = 3'h5;
  localparam logic [2:0] PK_BB_WR  = 3'h6;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_MODE   = 12'h000;
  localparam logic [11:0] OFF_LOCK   = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam int          LOCK_BIT   = 31;
  localparam logic        MODE_RST   = 1'h0;
  localparam logic [1:0]  MAX_OUTST  = 2'h3;
  localparam logic [31:0] NODE_BASE  = 32'hF800_0000;
  localparam logic [31:0] NODE_MASK  = 32'hFF80_0000;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SEM   = 5'h02,
    ST_PROBE = 5'h04,
    ST_ARB   = 5'h08,
    ST_WAIT  = 5'h10
  } cbb_state_type;

  typedef struct packed {
    logic [2:0]  kind;
    logic [31:0] addr;
  } cbb_preq_type;

  typedef struct packed {
    logic [2:0]  cmd;
    logic [31:0] addr;
    logic        own;
  } cbb_snoop_type;

  typedef struct packed {
    logic        bmap_hit;
    logic        valid;
    logic        dirty;
    logic        pmap_hit;
    logic        victim_match;
  } cbb_look_type;

  typedef struct packed {
    logic [2:0]  cmd;
    logic [31:0] addr;
  } cbb_bcmd_type;

endpackage : cbb_pkg

`default_nettype wire

// file: dv/cbb_bus_model.sv
// Behavioural system bus seen from the bridge: grant, latency, answer.
// Assumes one command in flight; the bench sets latency, data and shared.
`default_nettype none

module cbb_bus_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        bus_req,
  input  wire logic        bcmd_valid,
  input  wire logic [3:0]  lat,
  input  wire logic        shared_in,
  input  wire logic [31:0] data_in,
  output logic             bus_grant,
  output logic             bus_done,
  output logic             bus_shared,
  output logic [31:0]      bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [4:0] cnt_q;

  // Outside the answer cycle the data lines change every cycle, so a
  // bridge that samples them late sees garbage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= 5'h00;
      bus_grant  <= 1'b0;
      bus_done   <= 1'b0;
      bus_shared <= 1'b0;
      bus_rdata  <= 32'h0000_0000;
    end else begin
      bus_grant  <= bus_req && cnt_q == 5'h00 && !bcmd_valid;
      bus_done   <= cnt_q == 5'h01;
      bus_shared <= cnt_q == 5'h01 ? shared_in : ~bus_shared;
      bus_rdata  <= cnt_q == 5'h01 ? data_in : ~bus_rdata;
      if (bcmd_valid)
        cnt_q <= {1'b0, lat} + 5'h01;
      else if (cnt_q != 5'h00)
        cnt_q <= cnt_q - 5'h01;
    end
  end

endmodule : cbb_bus_model

`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the bridge: APB registers, processor requests
// and snoops. Assumes the bus model answers every command issued.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, proc_rdata, bus_rdata, dat, rd, q;
  logic        preq_valid, preq_ready, proc_done, proc_fail, fl, e;
  logic        bc_hit, bc_dirty, bus_req, bus_grant, bcmd_valid;
  logic        bus_done, bus_shared, shr, snoop_valid;
  logic        tag_capture, tag_update, pmap_update, bc_write, bb_write;
  logic        cache_access_semaphore, supply_data, pcache_inval;
  logic        bc_inval, csr_ack;
  logic [3:0]  lat;
  logic [9:0]  pv, seen;
  logic [31:0] A;
  cbb_pkg::cbb_preq_type  preq;
  cbb_pkg::cbb_snoop_type snoop;
  cbb_pkg::cbb_look_type  look;
  cbb_pkg::cbb_bcmd_type  bcmd;
  cbb_pkg::cbb_bcmd_type  cq[$];
  int          bad_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  cbb_bridge i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .preq_valid, .preq, .preq_ready,
    .proc_done, .proc_fail, .proc_rdata, .bc_hit, .bc_dirty, .tag_capture,
    .tag_update, .pmap_update, .bc_write, .bb_write, .bus_req, .bus_grant,
    .bcmd_valid, .bcmd, .bus_done, .bus_shared, .bus_rdata, .snoop_valid,
    .snoop, .look, .cache_access_semaphore, .supply_data, .pcache_inval,
    .bc_inval, .csr_ack);

  cbb_bus_model i_bus (.pclk, .presetn, .bus_req, .bcmd_valid, .lat,
    .shared_in(shr), .data_in(dat), .bus_grant, .bus_done, .bus_shared,
    .bus_rdata);

  assign pv = {cache_access_semaphore, csr_ack, bc_inval, pcache_inval,
               supply_data, bb_write, bc_write, pmap_update, tag_update,
               tag_capture};

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // --------------------------------------------------------------------
  // Monitor and timeout
  // --------------------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (presetn === 1'b1) begin
      seen <= seen | pv;
      if (bcmd_valid === 1'b1)
        cq.push_back(bcmd);
    end
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic cmp(input logic [63:0] g, input logic [63:0] x,
                     input string m);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR t=%0t %s got %0h exp %0h", $time, m, g, x);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic proc(input logic [2:0] k, input logic [31:0] a,
                      input logic [2:0] hds, input logic [9:0] m,
                      input logic [9:0] x, input int n);
    @(negedge pclk);
    seen = '0;
    cq.delete();
    do @(posedge pclk); while (preq_ready !== 1'b1);
    {bc_hit, bc_dirty, shr} <= hds;
    preq_valid <= 1'b1;
    preq       <= '{kind: k, addr: a};
    @(posedge pclk);
    preq_valid <= 1'b0;
    do @(posedge pclk); while (proc_done !== 1'b1);
    fl = proc_fail;
    rd = proc_rdata;
    do @(posedge pclk); while (preq_ready !== 1'b1);
    repeat (2) @(posedge pclk);
    cmp(64'(seen & m), 64'(x), "pulses");
    cmp(64'(cq.size()), 64'(n), "cmds");
  endtask : proc

  task automatic snp(input logic [2:0] c, input logic [31:0] a,
                     input logic o, input logic [4:0] l,
                     input logic [9:0] m, input logic [9:0] x);
    @(negedge pclk);
    seen = '0;
    @(posedge pclk);
    snoop_valid <= 1'b1;
    snoop       <= '{cmd: c, addr: a, own: o};
    look        <= l;
    @(posedge pclk);
    snoop_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    look <= ~l;
    repeat (2) @(posedge pclk);
    cmp(64'(seen & m), 64'(x), "snoop");
  endtask : snp

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    preq_valid = 1'b0;
    preq = '0;
    {bc_hit, bc_dirty, shr} = 3'h0;
    snoop_valid = 1'b0;
    snoop = '0;
    look = '0;
    lat = 4'h0;
    dat = 32'hA5A5_0001;
    seen = '0;
    A = 32'h0000_1240;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cbb_pkg::OFF_MODE, 32'h0);
    cmp(64'(q), 64'h0, "mode reset");
    apb(1'b0, cbb_pkg::OFF_LOCK, 32'h0);
    cmp(64'(q), 64'h0, "lock reset");
    apb(1'b1, cbb_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, cbb_pkg::OFF_STATUS, 32'h0);
    cmp(64'(q), 64'(cbb_pkg::ST_IDLE), "status");
    apb(1'b1, 12'h00C, 32'h1);
    cmp(64'(e), 64'h1, "unmapped wr");
    apb(1'b0, 12'h00C, 32'h0);
    cmp(64'(e), 64'h1, "unmapped rd");
    apb(1'b1, cbb_pkg::OFF_LOCK, 32'hFFFF_FFFF);
    apb(1'b0, cbb_pkg::OFF_LOCK, 32'h0);
    cmp(64'(q), 64'h8000_0000, "lock rw");
    apb(1'b1, cbb_pkg::OFF_LOCK, 32'h0);
    $display("register test done");
    proc(cbb_pkg::PK_DREAD, A, 3'h4, 10'h1FF, 10'h004, 0);
    proc(cbb_pkg::PK_READ_BLOCK_REQUEST, A, 3'h0, 10'h003, 10'h003, 1);
    cmp(64'(cq[0]), 64'({cbb_pkg::CMD_READ, A}), "rd cmd");
    cmp(64'(rd), 64'(dat), "rd data");
    lat <= 4'h5;
    proc(cbb_pkg::PK_WRITE_BLOCK_REQUEST, A, 3'h1, 10'h003, 10'h003, 2);
    cmp(64'(cq[1]), 64'({cbb_pkg::CMD_WRITE, A}), "shared wr");
    proc(cbb_pkg::PK_READ_BLOCK_REQUEST, A + 32'h40, 3'h2, 10'h003, 10'h003, 2);
    cmp(64'(cq[1].cmd), 64'(cbb_pkg::CMD_VICTIM), "victim");
    proc(cbb_pkg::PK_LDL, A, 3'h4, 10'h008, 10'h0, 0);
    apb(1'b0, cbb_pkg::OFF_LOCK, 32'h0);
    cmp(64'(q), 64'h8000_0000, "ll hit");
    proc(cbb_pkg::PK_STC, A, 3'h4, 10'h008, 10'h008, 0);
    apb(1'b0, cbb_pkg::OFF_LOCK, 32'h0);
    cmp(64'({fl, q}), 64'h0, "sc hit");
    proc(cbb_pkg::PK_STC, A, 3'h4, 10'h008, 10'h0, 0);
    cmp(64'(fl), 64'h1, "sc fail");
    proc(cbb_pkg::PK_LDL, A, 3'h0, 10'h0, 10'h0, 1);
    apb(1'b0, cbb_pkg::OFF_LOCK, 32'h0);
    cmp(64'(q), 64'h8000_0000, "ll miss");
    proc(cbb_pkg::PK_STC, A, 3'h0, 10'h008, 10'h0, 1);
    cmp(64'({fl, cq[0]}), 64'({cbb_pkg::CMD_WRITE, A}), "sc miss");
    dat <= 32'h0000_005A;
    proc(cbb_pkg::PK_BB_RD, 32'hF700_0040, 3'h0, 10'h0, 10'h0, 1);
    cmp(64'({cq[0].cmd, rd}), 64'({3'h7, dat}), "bb rd");
    proc(cbb_pkg::PK_BB_WR, 32'hF700_0080, 3'h0, 10'h010, 10'h010, 0);
    $display("processor test done");
    snp(cbb_pkg::CMD_READ, A, 1'b0, 5'h1C, 10'h3FF, 10'h220);
    snp(cbb_pkg::CMD_READ, A, 1'b0, 5'h18, 10'h3FF, 10'h200);
    snp(cbb_pkg::CMD_READ, A, 1'b0, 5'h19, 10'h3FF, 10'h220);
    snp(cbb_pkg::CMD_WRITE, A, 1'b0, 5'h1A, 10'h3FF, 10'h240);
    snp(cbb_pkg::CMD_WRITE, A, 1'b0, 5'h18, 10'h3FF, 10'h280);
    apb(1'b1, cbb_pkg::OFF_MODE, 32'h1);
    snp(cbb_pkg::CMD_WRITE, A, 1'b0, 5'h1A, 10'h3FF, 10'h2C0);
    snp(cbb_pkg::CMD_VICTIM, A, 1'b0, 5'h1C, 10'h3FF, 10'h0);
    snp(cbb_pkg::CMD_PRIV, A, 1'b0, 5'h1C, 10'h3FF, 10'h0);
    snp(cbb_pkg::CMD_CSR_RD, 32'hF800_0010, 1'b0, 5'h0, 10'h100, 10'h100);
    snp(cbb_pkg::CMD_CSR_WR, 32'hF800_0010, 1'b1, 5'h0, 10'h100, 10'h100);
    snp(cbb_pkg::CMD_CSR_RD, 32'hF700_0000, 1'b0, 5'h0, 10'h100, 10'h0);
    $display("snoop test done");
    wrap_up();
  end

endmodule : testbench

`default_nettype wire
